// ---- logic/urdl_dec_if.sv ----
// Interface: register select between decoder and register bank
interface urdl_dec_if;
  import urdl_pkg::*;
  logic [2:0]  ofs;
  logic        wr;
  logic [7:0]  line_control;
  logic [7:0]  enhanced_function;
  logic [7:0]  feature_control;
  logic        div_zero;
  logic        wr_hit;
  urdl_store_t wr_idx;
  logic        wr_thr;
  logic        wr_fcr;
  urdl_rsrc_t  rd_src;
  urdl_store_t rd_idx;
  modport bank (output ofs, output wr, output line_control, output enhanced_function,
                output feature_control, output div_zero, input wr_hit, input wr_idx,
                input wr_thr, input wr_fcr, input rd_src, input rd_idx);
  modport dec (input ofs, input wr, input line_control, input enhanced_function, input feature_control,
               input div_zero, output wr_hit, output wr_idx, output wr_thr,
               output wr_fcr, output rd_src, output rd_idx);
endinterface

// ---- logic/urdl_decode.sv ----
// Module: address decoder choosing a register by offset and mode bits
module urdl_decode
  import urdl_pkg::*;
(
  // Select carrier
  urdl_dec_if.dec d
);
  wire latch = d.line_control[LCR_LATCH_BIT];
  wire magic = (d.line_control == LCR_MAGIC);
  wire enh   = d.enhanced_function[EFR_ENH_BIT];
  wire fsel  = d.feature_control[FEATURE_CONTROL_SEL_BIT];
  wire dl    = latch && !magic;
  // Offset two standard set condition
  wire std2  = enh ? !latch : !magic;

  // Combinational selection of read source and write target
  always_comb begin
    d.wr_hit = 1'b0;
    d.wr_idx = S_DLL;
    d.wr_thr = 1'b0;
    d.wr_fcr = 1'b0;
    d.rd_src = RD_ZERO;
    d.rd_idx = S_DLL;
    case (d.ofs)
      OFS_0: begin
        if (magic) begin
          d.rd_src = RD_FC;
          d.wr_hit = 1'b1;
          d.wr_idx = S_TRG;
        end else if (dl) begin
          d.rd_src = d.div_zero ? RD_REV : RD_STORE;
          d.wr_hit = 1'b1;
          d.wr_idx = S_DLL;
          d.rd_idx = S_DLL;
        end else begin
          d.rd_src = RD_RHR;
          d.wr_thr = d.wr;
        end
      end
      OFS_1: begin
        d.wr_hit = 1'b1;
        d.rd_src = RD_STORE;
        if (magic) begin
          d.wr_idx = S_FEATURE_CONTROL;
          d.rd_idx = S_FEATURE_CONTROL;
        end else if (dl) begin
          d.wr_idx = S_DLM;
          d.rd_idx = S_DLM;
          if (d.div_zero) d.rd_src = RD_PART;
        end else begin
          d.wr_idx = S_IER;
          d.rd_idx = S_IER;
        end
      end
      OFS_2: begin
        if (magic) begin
          d.wr_hit = 1'b1;
          d.wr_idx = S_EFR;
          d.rd_src = RD_STORE;
          d.rd_idx = S_EFR;
        end else if (dl && enh) begin
          d.wr_hit = 1'b1;
          d.wr_idx = S_DLD;
          d.rd_src = RD_STORE;
          d.rd_idx = S_DLD;
        end else if (std2) begin
          d.rd_src = RD_ISR;
          d.wr_fcr = d.wr;
        end
      end
      OFS_3: begin
        d.wr_hit = 1'b1;
        d.wr_idx = S_LCR;
        d.rd_src = RD_STORE;
        d.rd_idx = S_LCR;
      end
      OFS_4, OFS_5: begin
        if (magic) begin
          d.wr_hit = 1'b1;
          d.wr_idx = (d.ofs == OFS_4) ? S_XN1 : S_XN2;
          d.rd_src = RD_STORE;
          d.rd_idx = d.wr_idx;
        end else if (d.ofs == OFS_4) begin
          d.wr_hit = 1'b1;
          d.wr_idx = S_MCR;
          d.rd_src = RD_STORE;
          d.rd_idx = S_MCR;
        end else begin
          d.rd_src = RD_LSR;
        end
      end
      OFS_6: begin
        if (magic) begin
          d.wr_hit = 1'b1;
          d.wr_idx = S_XF1;
          d.rd_src = RD_STORE;
          d.rd_idx = S_XF1;
        end else begin
          d.rd_src = RD_MSR;
          d.wr_hit = enh;
          d.wr_idx = S_OPT;
        end
      end
      default: begin
        d.wr_hit = 1'b1;
        if (magic) begin
          d.wr_idx = S_XF2;
          d.rd_src = RD_STORE;
          d.rd_idx = S_XF2;
        end else if (!fsel) begin
          d.wr_idx = S_SPR;
          d.rd_src = RD_STORE;
          d.rd_idx = S_SPR;
        end else begin
          d.wr_idx = S_OPT; // No store; top pulses mode select
          d.rd_src = RD_FC;
          d.wr_hit = 1'b0;
        end
      end
    endcase
  end
endmodule

// ---- logic/urdl_loop.sv ----
// Module: loopback steering of serial and modem pins
module urdl_loop (
  // Mode
  input  wire logic loop_en,
  // Core side
  input  wire logic tsr_out,
  input  wire logic rts_ctl,
  input  wire logic dtr_ctl,
  input  wire logic out1_ctl,
  input  wire logic out2_ctl,
  output logic      rsr_in,
  output logic [3:0] modem_in,
  // Pin side, already synchronised
  input  wire logic rx_pin,
  input  wire logic [3:0] modem_pin_n,
  output logic      tx_pin,
  output logic      rts_n_pin,
  output logic      dtr_n_pin
);
  // Receive path switches to the local shifter
  assign rsr_in    = loop_en ? tsr_out : rx_pin;
  // Mark level on the line while looped
  assign tx_pin    = loop_en ? 1'b1 : tsr_out;
  // Outputs de-asserted (high) while looped
  assign rts_n_pin = loop_en ? 1'b1 : !rts_ctl;
  assign dtr_n_pin = loop_en ? 1'b1 : !dtr_ctl;
  // Pins ignored; controls feed status so diagnostics still see edges
  assign modem_in  = loop_en ?
                     {out2_ctl, out1_ctl, dtr_ctl, rts_ctl} :
                     ~modem_pin_n;
endmodule

// ---- logic/urdl_pkg.sv ----
// Package: constants and types for the UART register decode and loopback
// What this block does
// - Modem control bit 4 turns loopback on
// - Loopback feeds transmit shifter into receiver
// - Loopback holds serial transmit pin high
// - Loopback de-asserts send request, terminal ready
// - Loopback ignores the four modem inputs
// - Other UART functions run unchanged in loopback
// - Latch mode selects divisor low and high
// - Divisor fraction needs latch mode, enhanced bit
// - Offset zero is receive/transmit holding normally
// - Offset two is interrupt status, fifo control
// - Offsets one, three, four, five standard registers
// - Offset six reads modem status, writes option when enhanced bit set
// - Offset seven is scratch pad when control clear
// - Offset seven is level count, mode select when control set
// - Magic line control selects enhanced function
// - Enhanced offset zero: level count, threshold
// - Enhanced offset one is feature control
// - Enhanced four to seven are flow characters
// - Zero divisor returns revision and identity
package urdl_pkg;
  // Register offsets, held at word index; byte address is index times four
  localparam logic [2:0] OFS_0 = 3'h0;
  localparam logic [2:0] OFS_1 = 3'h1;
  localparam logic [2:0] OFS_2 = 3'h2;
  localparam logic [2:0] OFS_3 = 3'h3;
  localparam logic [2:0] OFS_4 = 3'h4;
  localparam logic [2:0] OFS_5 = 3'h5;
  localparam logic [2:0] OFS_6 = 3'h6;
  localparam logic [2:0] OFS_7 = 3'h7;
  // Status word index: reports loopback state to the bus, writes ignored
  localparam logic [3:0] OFS_STAT_IDX = 4'h8;
  // Field positions
  localparam int LCR_LATCH_BIT = 7;
  localparam int EFR_ENH_BIT   = 4;
  localparam int MCR_LOOP_BIT  = 4;
  localparam int MCR_RTS_BIT   = 1;
  localparam int MCR_DTR_BIT   = 0;
  localparam int MCR_OUT1_BIT  = 2;
  localparam int MCR_OUT2_BIT  = 3;
  localparam int FEATURE_CONTROL_SEL_BIT  = 6;
  // Magic line control value and reset values
  localparam logic [7:0] LCR_MAGIC  = 8'hbf;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_LCR    = 8'h00;
  localparam logic [7:0] DIV_ZERO   = 8'h00;
  // Identity values: arbitrary
  localparam logic [7:0] ID_REV     = 8'h01;
  localparam logic [7:0] ID_PART    = 8'h5a;
  // Storage register indices
  localparam int N_STORE = 16;
  typedef enum logic [3:0] {
    S_DLL = 4'h0, S_DLM = 4'h1, S_DLD = 4'h2, S_IER = 4'h3,
    S_LCR = 4'h4, S_MCR = 4'h5, S_SPR = 4'h6, S_EFR = 4'h7,
    S_FEATURE_CONTROL = 4'h8, S_XN1 = 4'h9, S_XN2 = 4'ha, S_XF1 = 4'hb,
    S_XF2 = 4'hc, S_FCR = 4'hd, S_TRG = 4'he, S_OPT = 4'hf
  } urdl_store_t;
  // Bus phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_DATA = 2'b10
  } urdl_phase_t;
  // Selection of the read source
  typedef enum logic [3:0] {
    RD_STORE = 4'h0, RD_RHR = 4'h1, RD_ISR = 4'h2, RD_LSR = 4'h3,
    RD_MSR = 4'h4, RD_FC = 4'h5, RD_REV = 4'h6, RD_PART = 4'h7,
    RD_ZERO = 4'h8
  } urdl_rsrc_t;
endpackage

// ---- logic/urdl_top.sv ----
// Module: AHB-Lite register bank with decode and loopback for the UART
module urdl_top
  import urdl_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // UART core side
  input  wire logic        TSR_OUT,
  output logic             RSR_IN,
  input  wire logic [7:0]  RX_HOLD_DATA,
  input  wire logic [7:0]  INT_STATUS,
  input  wire logic [7:0]  LINE_STATUS,
  input  wire logic [3:0]  MODEM_DELTA,
  input  wire logic [7:0]  FIFO_LEVEL,
  output logic             TX_LOAD,
  output logic             RX_UNLOAD,
  output logic [7:0]       TX_DATA,
  output logic             FCR_LOAD,
  output logic             FIFO_THRESHOLD_LOAD,
  output logic             ENHANCED_MODE_SELECT_LOAD,
  output logic [7:0]       WR_DATA,
  output logic [3:0]       MODEM_IN,
  output logic             LOOP_ACTIVE,
  // Serial pins
  input  wire logic        RX,
  input  wire logic [3:0]  MODEM_N,
  output logic             TX,
  output logic             RTS_N,
  output logic             DTR_N
);
  // Storage and bus state
  logic [7:0]  store_reg [N_STORE];
  logic [2:0]  ofs_reg;
  logic        wr_reg;
  logic        act_reg;
  logic        stat_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  wdata_reg;
  logic        txl_reg;
  logic        fcr_reg;
  logic        trg_reg;
  logic        ems_reg;
  logic        rxu_reg;
  logic [1:0]  rx_sync_reg;
  logic [7:0]  modem_sync_reg;
  urdl_phase_t ph_reg;
  urdl_phase_t ph_next;

  urdl_dec_if dif ();

  // Address phase decode
  wire         take   = HSEL && HREADY && HTRANS[1];
  wire         in_map = (HADDR[31:5] == 27'h0) && (HADDR[1:0] == 2'b00);
  wire         is_st  = (HADDR[5:2] == OFS_STAT_IDX) && (HADDR[31:6] == 26'h0);
  wire [7:0]   wdat   = HWDATA[7:0];
  wire         rd_now = take && !HWRITE;
  // A read right behind a write waits one cycle, so it sees the new value
  wire         wr_hold = act_reg && wr_reg && HSEL && HTRANS[1] && !HWRITE;

  // Mode bits seen by the decoder
  assign dif.ofs      = (act_reg && wr_reg) ? ofs_reg : HADDR[4:2];
  assign dif.wr       = wr_reg;
  assign dif.line_control      = store_reg[S_LCR];
  assign dif.enhanced_function      = store_reg[S_EFR];
  assign dif.feature_control     = store_reg[S_FEATURE_CONTROL];
  assign dif.div_zero = (store_reg[S_DLL] == DIV_ZERO) &&
                        (store_reg[S_DLM] == DIV_ZERO);

  urdl_decode u_dec (
    .d (dif.dec)
  );

  wire [3:0]  modem_status_hi;

  // Read mux; address phase offset is used for reads
  function automatic logic [7:0] rd_pick(input urdl_rsrc_t s,
                                         input logic [7:0] st);
    case (s)
      RD_STORE: rd_pick = st;
      RD_RHR:   rd_pick = RX_HOLD_DATA;
      RD_ISR:   rd_pick = INT_STATUS;
      RD_LSR:   rd_pick = LINE_STATUS;
      RD_MSR:   rd_pick = {modem_status_hi, MODEM_DELTA};
      RD_FC:    rd_pick = FIFO_LEVEL;
      RD_REV:   rd_pick = ID_REV;
      RD_PART:  rd_pick = ID_PART;
      default:  rd_pick = RST_ZERO;
    endcase
  endfunction

  wire        loop_on = store_reg[S_MCR][MCR_LOOP_BIT];
  wire [7:0]  rd_byte = rd_pick(dif.rd_src, store_reg[dif.rd_idx]);
  wire        do_wr   = act_reg && wr_reg && !stat_reg;
  wire        fc7     = (ofs_reg == OFS_7) &&
                        (dif.line_control != LCR_MAGIC) &&
                        dif.feature_control[FEATURE_CONTROL_SEL_BIT];
  wire        trg_hit = do_wr && (ofs_reg == OFS_0) &&
                        (dif.line_control == LCR_MAGIC);

  // Mode bit applied at once from the modem control register
  assign LOOP_ACTIVE = loop_on;

  urdl_loop u_loop (
    .loop_en     (loop_on),
    .tsr_out     (TSR_OUT),
    .rts_ctl     (store_reg[S_MCR][MCR_RTS_BIT]),
    .dtr_ctl     (store_reg[S_MCR][MCR_DTR_BIT]),
    .out1_ctl    (store_reg[S_MCR][MCR_OUT1_BIT]),
    .out2_ctl    (store_reg[S_MCR][MCR_OUT2_BIT]),
    .rsr_in      (RSR_IN),
    .modem_in    (modem_status_hi),
    .rx_pin      (rx_sync_reg[1]),
    .modem_pin_n (modem_sync_reg[7:4]),
    .tx_pin      (TX),
    .rts_n_pin   (RTS_N),
    .dtr_n_pin   (DTR_N)
  );
  assign MODEM_IN = modem_status_hi;

  // Bus phase sequencing; only a read after a write waits
  always_comb begin
    case (ph_reg)
      PH_IDLE: ph_next = take ? PH_DATA : PH_IDLE;
      PH_DATA: ph_next = take ? PH_DATA : PH_IDLE;
      default: ph_next = PH_IDLE;
    endcase
  end

  // Outputs of the bus slave
  assign HREADYOUT = !wr_hold;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_reg;
  assign TX_DATA   = wdata_reg;
  assign WR_DATA   = wdata_reg;
  assign TX_LOAD   = txl_reg;
  assign FCR_LOAD  = fcr_reg;
  assign FIFO_THRESHOLD_LOAD = trg_reg;
  assign ENHANCED_MODE_SELECT_LOAD = ems_reg;
  assign RX_UNLOAD = rxu_reg;

  // Pin synchronisers, two stages each
  always_ff @(posedge CLK) begin
    rx_sync_reg    <= {rx_sync_reg[0], RX};
    modem_sync_reg <= {modem_sync_reg[3:0], MODEM_N};
  end

  // Address phase capture and read data
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ph_reg    <= PH_IDLE;
      act_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      stat_reg  <= 1'b0;
      ofs_reg   <= OFS_0;
      rdata_reg <= 32'h0;
      rxu_reg   <= 1'b0;
    end else begin
      ph_reg   <= ph_next;
      act_reg  <= take && (in_map || is_st);
      wr_reg   <= HWRITE;
      stat_reg <= is_st;
      ofs_reg  <= HADDR[4:2];
      rxu_reg  <= rd_now && in_map && (dif.rd_src == RD_RHR);
      if (rd_now) begin
        if (is_st) rdata_reg <= {31'h0, loop_on};
        else if (in_map) rdata_reg <= {24'h0, rd_byte};
        else rdata_reg <= 32'h0;
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < N_STORE; i++) store_reg[i] <= RST_ZERO;
      store_reg[S_LCR] <= RST_LCR;
      wdata_reg <= RST_ZERO;
      txl_reg   <= 1'b0;
      fcr_reg   <= 1'b0;
      trg_reg   <= 1'b0;
      ems_reg   <= 1'b0;
    end else begin
      txl_reg <= do_wr && dif.wr_thr;
      fcr_reg <= do_wr && dif.wr_fcr;
      trg_reg <= trg_hit;
      ems_reg <= do_wr && fc7;
      if (do_wr) wdata_reg <= wdat;
      if (do_wr && dif.wr_hit) begin
        store_reg[dif.wr_idx] <= wdat;
      end
    end
  end
  // Core keeps framing, FIFOs and interrupts running in loopback
endmodule

// ---- verification/urdl_asserts.sv ----
// Checker: loopback pins, receive routing and bus answer of the block
module urdl_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // Bus
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // Core side and pins
  input wire logic        TSR_OUT,
  input wire logic        RSR_IN,
  input wire logic        RX,
  input wire logic        TX,
  input wire logic        RTS_N,
  input wire logic        DTR_N,
  input wire logic [3:0]  MODEM_IN,
  input wire logic        LOOP_ACTIVE,
  input wire logic        TX_LOAD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Loopback isolates the line side
  chk_loop_mark: assert property (LOOP_ACTIVE |-> TX)
    else $error("tx not at mark in loopback");
  chk_loop_quiet: assert property (LOOP_ACTIVE |-> RTS_N && DTR_N)
    else $error("handshake output active in loopback");
  chk_loop_route: assert property (LOOP_ACTIVE |-> RSR_IN == TSR_OUT)
    else $error("receiver not fed from transmitter");
  // Two sync flops, so the pin arrives two edges late
  chk_line_route: assert property (
    !LOOP_ACTIVE && !$past(RESET, 2) |-> RSR_IN == $past(RX, 2))
    else $error("receiver not fed from line");
  chk_loop_enter: assert property ($changed(LOOP_ACTIVE) |->
    $past(HWRITE, 2) && LOOP_ACTIVE == $past(HWDATA[4]))
    else $error("loopback changed without control write");
  chk_modem_hold: assert property (
    LOOP_ACTIVE && $past(LOOP_ACTIVE) && $changed(MODEM_IN)
    |-> $past(HWRITE, 2))
    else $error("modem pins leak into loopback");
  chk_bus_okay: assert property (
    !HRESP && HRDATA[31:8] == 24'h0 && (HREADYOUT || $past(HREADYOUT)))
    else $error("bus answer malformed or wait too long");
  chk_load_pulse: assert property (TX_LOAD |=> !TX_LOAD)
    else $error("transmit load longer than one cycle");
  // Main scenarios
  cover property ($rose(LOOP_ACTIVE));
  cover property ($fell(LOOP_ACTIVE));
  cover property (TX_LOAD);
endmodule

bind urdl_top urdl_chk u_chk (.CLK, .RESET, .HWRITE, .HWDATA, .HRDATA,
  .HREADYOUT, .HRESP, .TSR_OUT, .RSR_IN, .RX, .TX, .RTS_N, .DTR_N,
  .MODEM_IN, .LOOP_ACTIVE, .TX_LOAD);

// ---- verification/urdl_host.sv ----
// Partner model: AHB-Lite master doing single word transfers
module urdl_host (
  // Clock, reset and request
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata,
  output logic             done,
  // Bus
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] st;
  assign hsize = 3'b010;
  // Quiet bus at time zero
  initial begin
    st = 2'd0;
    {hsel, haddr, htrans, hwrite, hwdata, rdata, done} = '0;
  end
  // Each phase is held until hready is seen high
  always @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      st <= 2'd0;
      htrans <= 2'b00;
    end else if (st == 2'd0 && go) begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= addr;
      hwrite <= wr;
      st <= 2'd1;
    end else if (st == 2'd1 && hready) begin
      htrans <= 2'b00;
      hwdata <= wr ? wdata : ~hwdata;
      st <= 2'd2;
    end else if (st == 2'd2 && hready) begin
      rdata <= hrdata;
      done <= 1'b1;
      hsel <= 1'b0;
      hwdata <= ~hwdata; // Released data must not look held
      st <= 2'd0;
    end
  end
endmodule

// ---- verification/urdl_tb.sv ----
// Testbench: register decode and loopback of the UART register block
module tb
  import urdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 1'b0, RESET = 1'b1, go = 1'b0, wr = 1'b0, tsr = 1'b0;
  logic rx = 1'b1, done, hsel, hwrite, hrdy, tx, rsr, loop, rts_n, dtr_n;
  logic [31:0] addr = '0, wdata = '0, rdata, haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] mdm_n = 4'ha, mdelta = 4'h5, mdm_in;
  logic [7:0] rhd = 8'h3c, interrupt_status = 8'hc1, line_status = 8'h60, lvl = 8'h07;
  logic [4:0] ld;
  logic [7:0] txd, wrd;
  int fail_count = 0, total_checks = 0;
  int npl[5] = '{0, 0, 0, 0, 0};
  int nexp[5] = '{1, 2, 1, 1, 1};
  always #25 CLK = ~CLK;
  urdl_host u_host (.clk(CLK), .rst(RESET), .go, .wr, .addr, .wdata,
    .rdata, .done, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hrdy), .hrdata);
  urdl_top dut (.CLK, .RESET, .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hrdy), .HWDATA(hwdata),
    .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(), .TSR_OUT(tsr),
    .RSR_IN(rsr), .RX_HOLD_DATA(rhd), .INT_STATUS(interrupt_status), .LINE_STATUS(line_status),
    .MODEM_DELTA(mdelta), .FIFO_LEVEL(lvl), .TX_LOAD(ld[0]),
    .FCR_LOAD(ld[1]), .FIFO_THRESHOLD_LOAD(ld[2]), .ENHANCED_MODE_SELECT_LOAD(ld[3]),
    .RX_UNLOAD(ld[4]), .TX_DATA(txd), .WR_DATA(wrd), .MODEM_IN(mdm_in),
    .LOOP_ACTIVE(loop), .RX(rx), .MODEM_N(mdm_n), .TX(tx), .RTS_N(rts_n),
    .DTR_N(dtr_n));
  // Count strobes from the register writes and holding reads
  always @(posedge CLK) begin
    foreach (npl[i]) npl[i] += (ld[i] === 1'b1);
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One transfer through the host model, waiting for its completion
  task automatic xfer(input logic w, input logic [3:0] o, input logic [7:0] d);
    @(posedge CLK);
    go <= 1'b1;
    wr <= w;
    addr <= {26'h0, o, 2'b00};
    wdata <= {24'h0, d};
    @(posedge CLK);
    go <= 1'b0;
    repeat (20) begin
      @(posedge CLK);
      #1;
      if (done === 1'b1) break;
    end
    if (done !== 1'b1) fail_count++;
  endtask
  task automatic rd(input logic [3:0] o, input logic [7:0] e);
    xfer(1'b0, o, 8'h00);
    cmp(rdata, {24'h0, e});
  endtask
  // Drive pins, let the sync chain settle, then look at the line side
  task automatic pins(input logic t, input logic [3:0] m, input logic [8:0] e);
    @(posedge CLK);
    tsr <= t;
    mdm_n <= m;
    repeat (3) @(posedge CLK);
    #1;
    cmp({loop, tx, rts_n, dtr_n, rsr, mdm_in}, e);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard: the tests need well under a thousand cycles
  initial begin
    #(50 * 3000);
    fail_count++;
    conclude();
  end
  // Tests
  initial begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    rd(4'h4, 8'h00);
    xfer(1'b1, 4'h3, 8'h03);
    rd(4'h3, 8'h03);
    xfer(1'b1, 4'h1, 8'h0f);
    rd(4'h1, 8'h0f);
    xfer(1'b1, 4'h7, 8'ha5);
    rd(4'h7, 8'ha5);
    rd(4'h0, rhd);
    rd(4'h2, interrupt_status);
    rd(4'h5, line_status);
    rd(4'h6, {~mdm_n, mdelta});
    xfer(1'b1, 4'h0, 8'h5e);
    cmp({16'h0, txd, wrd}, 32'h5e5e);
    xfer(1'b1, 4'h2, 8'h07);
    // Latch mode: identity while the divisor is zero
    xfer(1'b1, 4'h3, 8'h80);
    rd(4'h0, ID_REV);
    rd(4'h1, ID_PART);
    rd(4'h2, interrupt_status);
    xfer(1'b1, 4'h0, 8'h12);
    rd(4'h0, 8'h12);
    rd(4'h1, 8'h00);
    xfer(1'b1, 4'h1, 8'h34);
    rd(4'h1, 8'h34);
    // Enhanced set behind the magic line control value
    xfer(1'b1, 4'h3, LCR_MAGIC);
    xfer(1'b1, 4'h2, 8'h10);
    rd(4'h2, 8'h10);
    xfer(1'b1, 4'h1, 8'h40);
    rd(4'h1, 8'h40);
    for (int i = 4; i < 8; i++) xfer(1'b1, i[3:0], 8'hc0 + i[7:0]);
    for (int i = 4; i < 8; i++) rd(i[3:0], 8'hc0 + i[7:0]);
    rd(4'h0, lvl);
    xfer(1'b1, 4'h0, 8'h21);
    xfer(1'b1, 4'h3, 8'h80);
    xfer(1'b1, 4'h2, 8'h05);
    rd(4'h2, 8'h05);
    xfer(1'b1, 4'h3, 8'h00);
    rd(4'h2, interrupt_status);
    rd(4'h7, lvl);
    xfer(1'b1, 4'h7, 8'h03);
    xfer(1'b1, 4'h2, 8'h01);
    xfer(1'b1, 4'h6, 8'h80);
    rd(4'h6, {~mdm_n, mdelta});
    xfer(1'b1, 4'h3, LCR_MAGIC);
    xfer(1'b1, 4'h1, 8'h00);
    xfer(1'b1, 4'h3, 8'h00);
    rd(4'h7, 8'ha5);
    foreach (npl[i]) cmp(npl[i], nexp[i]);
    // Loopback; rx stays high while looped to avoid a false break
    xfer(1'b1, 4'h4, 8'h13);
    pins(1'b0, 4'h0, {5'b11110, 4'h3});
    pins(1'b1, 4'hf, {5'b11111, 4'h3});
    rd(4'h8, 8'h01);
    rd(4'h5, line_status);
    rd(4'h9, 8'h00);
    // Control outputs reach modem status while looped, pins do not
    xfer(1'b1, 4'h4, 8'h1c);
    pins(1'b1, 4'h0, {5'b11111, 4'hc});
    xfer(1'b1, 4'h4, 8'h03);
    pins(1'b0, 4'h6, {5'b00001, 4'h9});
    @(posedge CLK);
    rx <= 1'b0;
    pins(1'b1, 4'h6, {5'b01000, 4'h9});
    conclude();
  end
endmodule
